/* ectl_init_top.sv */
// Init and configuration block of the Ethernet controller with a Wishbone slave
// Functional notes
// - Master reset starts system reset; 25 us quiet
// - System reset returns scratch pointer to zero
// - Clock output runs 4 MHz after power-on
// - Clock select survives all but power-on reset
// - Receive buffer spans start pointer to 5FFFh
// - First packet stored at receive start pointer
// - Transmit frames accepted from any region
// - Max frame length bounds both directions unless huge
// - Station address reloaded after every reset
// - Busy wait, backpressure, skip backoff half-duplex only
// - Retry limit bounds retransmissions after collision
// - Half duplex gap is register plus 6
// - Full duplex gap is register plus 3
// - Master reset bit clears itself in hardware
`timescale 1ns/1ps
module ectl_init_top
  import ectl_pkg::*;
#(
  parameter logic [47:0] FACTORY_ADDR = 48'h02_00_00_00_00_01 // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // PHY status pin
  input  wire logic        phy_duplex_status_i,
  // Receive data path
  input  wire logic        rx_byte_i,
  input  wire logic [15:0] rx_frame_len_i,
  output logic [15:0]      rx_wr_addr_o,
  output logic             rx_len_ok_o,
  output logic             receive_enable_o,
  // Transmit data path
  input  wire logic [15:0] tx_start_addr_i,
  input  wire logic [15:0] tx_frame_len_i,
  input  wire logic        tx_done_i,
  output logic [15:0]      tx_rd_addr_o,
  output logic             tx_len_ok_o,
  output logic             tx_gap_busy_o,
  // MAC settings seen by the data path
  output logic             busy_wait_o,
  output logic             backpressure_o,
  output logic             skip_backoff_o,
  output logic [3:0]       retry_limit_o,
  output logic [47:0]      station_addr_o,
  output logic             sys_reset_busy_o,
  // Clock output pin
  output logic             clock_output_pin_o
);
  // Control state
  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,  // Waiting for the clock to settle
    ST_RUN  = 3'b010,  // Normal operation
    ST_SRST = 3'b100   // System reset in progress
  } ectl_state_e;

  ectl_state_e state, next_state;
  logic [10:0] rst_cnt, next_rst_cnt;     // System reset hold counter
  logic [5:0]  rdy_cnt, next_rdy_cnt;     // Clock settle counter
  logic        clk_ready, next_clk_ready;
  // Registers
  logic [15:0] scratch, next_scratch;
  logic [15:0] ctrl_one, next_ctrl_one;
  logic [15:0] ctrl_two, next_ctrl_two;
  logic [15:0] rx_start, next_rx_start;
  logic [15:0] max_frame, next_max_frame;
  logic [15:0] mac_ctrl_two, next_mac_ctrl_two;
  logic [15:0] nbb_gap, next_nbb_gap;
  logic [15:0] bb_gap, next_bb_gap;
  logic [15:0] coll_ctrl, next_coll_ctrl;
  logic [47:0] sta_addr, next_sta_addr;
  // Bus and data path
  logic        next_ack;
  logic [31:0] next_dat;
  logic [15:0] rd_word;
  logic [15:0] next_rx_wr_addr;
  logic        rx_en_d, next_rx_en_d;
  logic        next_rx_ok, next_tx_ok;
  logic        duplex_meta, duplex_sync;  // Pin synchroniser
  logic        wr_req, rd_req;
  logic        full_dpx;

  // Merge a write into a 16-bit register under the two low byte lanes
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
    wmerge = old;
    if (sel[0]) begin
      wmerge[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      wmerge[15:8] = wd[15:8];
    end
  endfunction

  // Frame fits unless the limit is exceeded and huge frames are off
  function automatic logic len_fits(input logic [15:0] len, input logic [15:0] lim,
                                    input logic huge);
    len_fits = huge || (len <= lim);
  endfunction

  assign wr_req   = cyc_i && stb_i && !ack_o && we_i;
  assign rd_req   = cyc_i && stb_i && !ack_o && !we_i;
  assign full_dpx = mac_ctrl_two[BIT_FULL_DUPLEX];

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    case (adr_i)
      OFS_SCRATCH:      rd_word = scratch;
      OFS_STATUS:       rd_word = 16'((32'(clk_ready) << BIT_CLK_READY) | (32'(duplex_sync) << BIT_PHY_DUPLEX));
      OFS_CTRL_ONE:     rd_word = ctrl_one;
      OFS_CTRL_TWO:     rd_word = ctrl_two;
      OFS_RX_START:     rd_word = rx_start;
      OFS_MAX_FRAME:    rd_word = max_frame;
      OFS_MAC_CTRL_TWO: rd_word = mac_ctrl_two;
      OFS_NBB_GAP:      rd_word = nbb_gap;
      OFS_BB_GAP:       rd_word = bb_gap;
      OFS_COLL_CTRL:    rd_word = coll_ctrl;
      OFS_STA_ADDR0:    rd_word = sta_addr[15:0];
      OFS_STA_ADDR1:    rd_word = sta_addr[31:16];
      OFS_STA_ADDR2:    rd_word = sta_addr[47:32];
      default:          rd_word = 16'h0000;
    endcase
  end

  // Next state of control, registers and bus answer
  always_comb begin
    next_state        = state;
    next_rst_cnt      = rst_cnt;
    next_rdy_cnt      = rdy_cnt;
    next_clk_ready    = clk_ready;
    next_scratch      = scratch;
    next_ctrl_one     = ctrl_one;
    next_ctrl_two     = ctrl_two;
    next_rx_start     = rx_start;
    next_max_frame    = max_frame;
    next_mac_ctrl_two = mac_ctrl_two;
    next_nbb_gap      = nbb_gap;
    next_bb_gap       = bb_gap;
    next_coll_ctrl    = coll_ctrl;
    next_sta_addr     = sta_addr;
    // Every access is answered one cycle later, even during a system reset
    next_ack          = cyc_i && stb_i && !ack_o;
    next_dat          = 32'h0000_0000;
    case (state)
      ST_BOOT: begin
        // Clock ready rises after the settle time
        if (rdy_cnt == 6'(CLK_READY_CYCLES - 1)) begin
          next_clk_ready = 1'b1;
          next_state     = ST_RUN;
        end else begin
          next_rdy_cnt = rdy_cnt + 6'h01;
        end
      end
      ST_RUN: begin
        if (rd_req) begin
          next_dat = {16'h0000, rd_word};
        end
        if (wr_req) begin
          case (adr_i)
            OFS_SCRATCH:      next_scratch      = wmerge(scratch, dat_i, sel_i);
            OFS_CTRL_ONE:     next_ctrl_one     = wmerge(ctrl_one, dat_i, sel_i);
            OFS_CTRL_TWO:     next_ctrl_two     = wmerge(ctrl_two, dat_i, sel_i);
            OFS_RX_START:     next_rx_start     = wmerge(rx_start, dat_i, sel_i);
            OFS_MAX_FRAME:    next_max_frame    = wmerge(max_frame, dat_i, sel_i);
            OFS_MAC_CTRL_TWO: next_mac_ctrl_two = wmerge(mac_ctrl_two, dat_i, sel_i);
            OFS_NBB_GAP:      next_nbb_gap      = wmerge(nbb_gap, dat_i, sel_i);
            OFS_BB_GAP:       next_bb_gap       = wmerge(bb_gap, dat_i, sel_i);
            OFS_COLL_CTRL:    next_coll_ctrl    = wmerge(coll_ctrl, dat_i, sel_i);
            // Host writes touch only the registers, the factory copy stays
            OFS_STA_ADDR0:    next_sta_addr[15:0]  = wmerge(sta_addr[15:0], dat_i, sel_i);
            OFS_STA_ADDR1:    next_sta_addr[31:16] = wmerge(sta_addr[31:16], dat_i, sel_i);
            OFS_STA_ADDR2:    next_sta_addr[47:32] = wmerge(sta_addr[47:32], dat_i, sel_i);
            default:          next_scratch      = scratch;
          endcase
          // Master reset bit starts a system reset
          if (adr_i == OFS_CTRL_TWO && sel_i[0] && dat_i[BIT_MASTER_RST]) begin
            next_state   = ST_SRST;
            next_rst_cnt = 11'h000;
          end
        end
      end
      ST_SRST: begin
        // Bus is deaf for the hold time: writes dropped, reads zero
        next_scratch      = RST_SCRATCH;
        next_ctrl_one     = RST_CTRL_ONE;
        // Clock select keeps its value; the reset bit stays set meanwhile
        next_ctrl_two     = (RST_CTRL_TWO & 16'hf0ff) | (ctrl_two & 16'h0f00)
                            | 16'(32'h1 << BIT_MASTER_RST);
        next_rx_start     = RST_RX_START;
        next_max_frame    = RST_MAX_FRAME;
        next_mac_ctrl_two = RST_MAC_CTRL_TWO;
        next_nbb_gap      = RST_NBB_GAP;
        next_bb_gap       = RST_BB_GAP;
        next_coll_ctrl    = RST_COLL_CTRL;
        next_sta_addr     = FACTORY_ADDR;
        if (rst_cnt == 11'(SYSRST_CYCLES - 1)) begin
          next_ctrl_two[BIT_MASTER_RST] = 1'b0;
          next_state                    = ST_RUN;
        end else begin
          next_rst_cnt = rst_cnt + 11'h001;
        end
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
  end

  // Control and register flops; power-on reset loads every default
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state        <= ST_BOOT;
      rst_cnt      <= 11'h000;
      rdy_cnt      <= 6'h00;
      clk_ready    <= 1'b0;
      scratch      <= RST_SCRATCH;
      ctrl_one     <= RST_CTRL_ONE;
      ctrl_two     <= RST_CTRL_TWO;
      rx_start     <= RST_RX_START;
      max_frame    <= RST_MAX_FRAME;
      mac_ctrl_two <= RST_MAC_CTRL_TWO;
      nbb_gap      <= RST_NBB_GAP;
      bb_gap       <= RST_BB_GAP;
      coll_ctrl    <= RST_COLL_CTRL;
      sta_addr     <= FACTORY_ADDR;
      ack_o        <= 1'b0;
      dat_o        <= 32'h0000_0000;
    end else begin
      state        <= next_state;
      rst_cnt      <= next_rst_cnt;
      rdy_cnt      <= next_rdy_cnt;
      clk_ready    <= next_clk_ready;
      scratch      <= next_scratch;
      ctrl_one     <= next_ctrl_one;
      ctrl_two     <= next_ctrl_two;
      rx_start     <= next_rx_start;
      max_frame    <= next_max_frame;
      mac_ctrl_two <= next_mac_ctrl_two;
      nbb_gap      <= next_nbb_gap;
      bb_gap       <= next_bb_gap;
      coll_ctrl    <= next_coll_ctrl;
      sta_addr     <= next_sta_addr;
      ack_o        <= next_ack;
      dat_o        <= next_dat;
    end
  end

  // Receive pointer: loads the start on enable, wraps past the last address
  always_comb begin
    next_rx_en_d    = ctrl_one[BIT_RX_ENABLE];
    next_rx_wr_addr = rx_wr_addr_o;
    if (ctrl_one[BIT_RX_ENABLE] && !rx_en_d) begin
      next_rx_wr_addr = rx_start;
    end else if (ctrl_one[BIT_RX_ENABLE] && rx_byte_i) begin
      if (rx_wr_addr_o >= RX_BUF_LAST) begin
        next_rx_wr_addr = rx_start;
      end else begin
        next_rx_wr_addr = rx_wr_addr_o + 16'h0001;
      end
    end
    // One limit covers both directions unless huge frames are on
    next_rx_ok = len_fits(rx_frame_len_i, max_frame, mac_ctrl_two[BIT_HUGE_FRAME]);
    next_tx_ok = len_fits(tx_frame_len_i, max_frame, mac_ctrl_two[BIT_HUGE_FRAME]);
  end

  // Data path flops; the synchroniser's first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_en_d      <= 1'b0;
      rx_wr_addr_o <= RST_RX_START;
      rx_len_ok_o  <= 1'b0;
      tx_len_ok_o  <= 1'b0;
      tx_rd_addr_o <= 16'h0000;
      duplex_meta  <= 1'b0;
      duplex_sync  <= 1'b0;
    end else begin
      rx_en_d      <= next_rx_en_d;
      rx_wr_addr_o <= next_rx_wr_addr;
      rx_len_ok_o  <= next_rx_ok;
      tx_len_ok_o  <= next_tx_ok;
      tx_rd_addr_o <= tx_start_addr_i;
      duplex_meta  <= phy_duplex_status_i;
      duplex_sync  <= duplex_meta;
    end
  end

  // Half-duplex-only options are masked off in full duplex
  assign busy_wait_o      = !full_dpx && mac_ctrl_two[BIT_BUSY_WAIT];
  assign backpressure_o   = !full_dpx && mac_ctrl_two[BIT_BACKPRESSURE];
  assign skip_backoff_o   = !full_dpx && mac_ctrl_two[BIT_SKIP_BACKOFF];
  assign retry_limit_o    = coll_ctrl[3:0];
  assign receive_enable_o = ctrl_one[BIT_RX_ENABLE];
  assign station_addr_o   = sta_addr;
  assign sys_reset_busy_o = (state == ST_SRST);

  // Back-to-back gap timing
  ectl_gap_timer u_gap (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .gap_i         (bb_gap[6:0]),
    .full_duplex_i (full_dpx),
    .tx_done_i     (tx_done_i),
    .gap_busy_o    (tx_gap_busy_o)
  );

  // Clock output pin
  ectl_clock_output_pin_gen u_clock_output_pin (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .sel_i     (ctrl_two[COSEL_LSB +: 4]),
    .clk_out_o (clock_output_pin_o)
  );
endmodule

/* ectl_pkg.sv */
// Package with register map, reset values and timing constants of the init block
package ectl_pkg;
  // Clock and timing
  localparam int          CLK_MHZ          = 50;
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          SYSRST_HOLD_US   = 25;
  localparam int          SYSRST_CYCLES    = SYSRST_HOLD_US * CLK_MHZ;
  localparam int          CLK_READY_NS     = 1000;
  localparam int          CLK_READY_CYCLES = (CLK_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NIBBLE_NS        = 40;
  localparam int          NIBBLE_CYCLES    = NIBBLE_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  HALF_GAP_OFFSET  = 4'h6;
  localparam logic [3:0]  FULL_GAP_OFFSET  = 4'h3;
  // Register byte offsets on the bus
  localparam logic [5:0]  OFS_SCRATCH      = 6'h00;
  localparam logic [5:0]  OFS_STATUS       = 6'h04;
  localparam logic [5:0]  OFS_CTRL_ONE     = 6'h08;
  localparam logic [5:0]  OFS_CTRL_TWO     = 6'h0c;
  localparam logic [5:0]  OFS_RX_START     = 6'h10;
  localparam logic [5:0]  OFS_MAX_FRAME    = 6'h14;
  localparam logic [5:0]  OFS_MAC_CTRL_TWO = 6'h18;
  localparam logic [5:0]  OFS_NBB_GAP      = 6'h1c;
  localparam logic [5:0]  OFS_BB_GAP       = 6'h20;
  localparam logic [5:0]  OFS_COLL_CTRL    = 6'h24;
  localparam logic [5:0]  OFS_STA_ADDR0    = 6'h28;
  localparam logic [5:0]  OFS_STA_ADDR1    = 6'h2c;
  localparam logic [5:0]  OFS_STA_ADDR2    = 6'h30;
  // Field positions
  localparam int          BIT_RX_ENABLE    = 0;
  localparam int          BIT_MASTER_RST   = 4;
  localparam int          COSEL_LSB        = 8;
  localparam int          BIT_PHY_DUPLEX   = 10;
  localparam int          BIT_CLK_READY    = 12;
  localparam int          BIT_FULL_DUPLEX  = 0;
  localparam int          BIT_HUGE_FRAME   = 2;
  localparam int          BIT_SKIP_BACKOFF = 12;
  localparam int          BIT_BACKPRESSURE = 13;
  localparam int          BIT_BUSY_WAIT    = 14;
  // Reset values
  localparam logic [15:0] RST_SCRATCH      = 16'h0000;
  localparam logic [15:0] RST_CTRL_ONE     = 16'h0000;
  localparam logic [15:0] RST_CTRL_TWO     = 16'hcb00;
  localparam logic [15:0] RST_RX_START     = 16'h0000;
  localparam logic [15:0] RST_MAX_FRAME    = 16'h05ee;
  localparam logic [15:0] RST_MAC_CTRL_TWO = 16'h40b2;
  localparam logic [15:0] RST_NBB_GAP      = 16'h0012;
  localparam logic [15:0] RST_BB_GAP       = 16'h0012;
  localparam logic [15:0] RST_COLL_CTRL    = 16'h000f;
  localparam logic [15:0] RX_BUF_LAST      = 16'h5fff;
  // Clock output select codes that give no output
  localparam logic [3:0]  COSEL_OFF_A      = 4'h0;
  localparam logic [3:0]  COSEL_OFF_B      = 4'hd;
endpackage

/* ectl_clock_output_pin_gen.sv */
// Clock output pin generator driven by a fractional phase accumulator
`timescale 1ns/1ps
module ectl_clock_output_pin_gen
  import ectl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Frequency select
  input  wire logic [3:0] sel_i,
  // Pin
  output logic            clk_out_o
);
  logic [11:0] acc;        // Phase in 200 MHz ticks
  logic [11:0] next_acc;
  logic        next_clk_out;
  logic [11:0] period;     // Period in 200 MHz ticks

  // Period table; fractional dividers average out through the accumulator
  always_comb begin
    case (sel_i)
      4'hf:    period = 12'hfa0;
      4'he:    period = 12'h7d0;
      4'hc:    period = 12'h040;
      4'hb:    period = 12'h032;
      4'ha:    period = 12'h028;
      4'h9:    period = 12'h020;
      4'h8:    period = 12'h019;
      4'h7:    period = 12'h018;
      4'h6:    period = 12'h014;
      4'h5:    period = 12'h010;
      4'h4:    period = 12'h00c;
      4'h3:    period = 12'h00a;
      4'h2:    period = 12'h008;
      4'h1:    period = 12'h006;
      default: period = 12'h000;
    endcase
  end

  // Advance by four ticks per 50 MHz cycle and wrap at the period
  always_comb begin
    next_acc     = acc + 12'h004;
    if (period == 12'h000 || sel_i == COSEL_OFF_B) begin
      next_acc     = 12'h000;
      next_clk_out = 1'b0;                   // Pin held low when off
    end else begin
      if (next_acc >= period) begin
        next_acc = next_acc - period;
      end
      next_clk_out = (next_acc < {1'b0, period[11:1]});
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc       <= 12'h000;
      clk_out_o <= 1'b0;
    end else begin
      acc       <= next_acc;
      clk_out_o <= next_clk_out;
    end
  end
endmodule

/* ectl_gap_timer.sv */
// Back-to-back inter-packet gap timer that follows the duplex mode
`timescale 1ns/1ps
module ectl_gap_timer
  import ectl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Settings
  input  wire logic [6:0] gap_i,
  input  wire logic       full_duplex_i,
  // Transmit events
  input  wire logic       tx_done_i,
  output logic            gap_busy_o
);
  logic [11:0] count;        // Cycles left in the gap
  logic [11:0] next_count;
  logic [7:0]  nibbles;      // Gap in nibble times

  // Gap is the register plus a duplex dependent offset
  always_comb begin
    if (full_duplex_i) begin
      nibbles = {1'b0, gap_i} + {4'h0, FULL_GAP_OFFSET};
    end else begin
      nibbles = {1'b0, gap_i} + {4'h0, HALF_GAP_OFFSET};
    end
  end

  // Restart on every finished frame, else count down
  always_comb begin
    next_count = count;
    if (tx_done_i) begin
      next_count = 12'(nibbles * NIBBLE_CYCLES);
    end else if (count != 12'h000) begin
      next_count = count - 12'h001;
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= 12'h000;
    end else begin
      count <= next_count;
    end
  end

  assign gap_busy_o = (count != 12'h000);
endmodule

/* ectl_init_chk.sv */
// Checker of bus answers, receive pointer, gap and system reset timing
`timescale 1ns/1ps
module ectl_init_chk
  import ectl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        ack_o,
  input  wire logic [31:0] dat_o,
  // Data path
  input  wire logic        rx_byte_i,
  input  wire logic        receive_enable_o,
  input  wire logic [15:0] rx_wr_addr_o,
  input  wire logic [15:0] tx_start_addr_i,
  input  wire logic [15:0] tx_rd_addr_o,
  input  wire logic        tx_done_i,
  input  wire logic        tx_gap_busy_o,
  input  wire logic        sys_reset_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [11:0] hold_q;    // Length of the running system reset hold
  logic [11:0] next_hold;
  logic [8:0]  gap_q;     // Length of the running gap
  logic [8:0]  next_gap;
  // Run lengths restart whenever the level drops
  always_comb begin
    next_hold = sys_reset_busy_o ? hold_q + 12'h001 : 12'h000;
    next_gap  = tx_gap_busy_o ? gap_q + 9'h001 : 9'h000;
  end
  // Counters cleared by reset so a second reset starts clean
  always_ff @(posedge clk_i) begin
    hold_q <= rst_n_i ? next_hold : 12'h000;
    gap_q  <= rst_n_i ? next_gap : 9'h000;
  end
  ack_one_a: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  hold_min_a: assert property ($fell(sys_reset_busy_o) |-> hold_q >= 12'h4e2)
    else $error("system reset hold too short");
  hold_max_a: assert property (sys_reset_busy_o |-> hold_q < 12'h4ec) else $error("system reset hold too long");
  tx_copy_a: assert property ($past(rst_n_i) |-> tx_rd_addr_o == $past(tx_start_addr_i))
    else $error("transmit address not taken");
  gap_cause_a: assert property ($rose(tx_gap_busy_o) |-> $past(tx_done_i)) else $error("gap without end");
  gap_len_a: assert property (tx_gap_busy_o |-> gap_q < 9'h10a) else $error("gap too long");
  rx_step_a: assert property (receive_enable_o && $past(receive_enable_o) && $past(rx_byte_i)
    && $past(rx_wr_addr_o) < 16'h5fff |-> rx_wr_addr_o == $past(rx_wr_addr_o) + 16'h0001) else $error("bad step");
  rx_bound_a: assert property (receive_enable_o && $past(receive_enable_o) |-> rx_wr_addr_o <= 16'h5fff)
    else $error("receive pointer past buffer end");
  cover property ($fell(sys_reset_busy_o));
  cover property ($rose(tx_gap_busy_o));
  cover property (rx_byte_i && receive_enable_o);
endmodule

bind ectl_init_top ectl_init_chk u_chk (.*);

/* ectl_host_model.sv */
// Host controller model driving the register port
`timescale 1ns/1ps
module ectl_host_model
  import ectl_pkg::*;
(
  // Clock and answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // Request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [5:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  bit to_seen = 1'b0; // Set once a wait for ack runs out
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 6'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // One classic cycle; a released address and data show the inverse so stale values never pass
  task automatic xfer(input bit w, input logic [5:0] a, input logic [15:0] d, output logic [15:0] r);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    dat_o <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 32);
    r = dat_i[15:0];
    if (ack_i !== 1'b1) to_seen = 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~{16'h0000, d};
  endtask
  // Start-up: verify scratch, wait for clock, system reset, verify again
  task automatic init_seq(input logic [15:0] ctl2, output bit ok);
    logic [15:0] r;
    int n;
    ok = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin // Bounded so a dead port cannot hang start-up
      xfer(1'b1, OFS_SCRATCH, 16'h1234, r);
      xfer(1'b0, OFS_SCRATCH, 16'h0000, r);
      ok = (r === 16'h1234);
    end
    r = 16'h0000;
    for (n = 0; n < 40 && r[BIT_CLK_READY] !== 1'b1; n++) xfer(1'b0, OFS_STATUS, 16'h0000, r);
    xfer(1'b1, OFS_CTRL_TWO, ctl2 | 16'h0010, r);
    repeat (SYSRST_CYCLES + 4) @(posedge clk_i); // Quiet time
    xfer(1'b0, OFS_SCRATCH, 16'h0000, r);
    ok = ok && r === 16'h0000 && !to_seen;
  endtask
endmodule

/* tb_top.sv */
// Testbench: start-up, clock output, lengths, receive pointer, duplex settings
`timescale 1ns/1ps
module tb_top;
  import ectl_pkg::*;
  localparam logic [47:0] FADDR = 48'h0a0b_0c0d_0e0f; // Arbitrary factory address
  logic        clk_i, rst_n_i, cyc_i, stb_i, we_i, ack_o, phy_duplex_status_i, rx_byte_i, tx_done_i;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i, retry_limit_o;
  logic [31:0] dat_i, dat_o;
  logic [15:0] rx_frame_len_i, tx_start_addr_i, tx_frame_len_i, rx_wr_addr_o, tx_rd_addr_o;
  logic        rx_len_ok_o, receive_enable_o, tx_len_ok_o, tx_gap_busy_o, busy_wait_o, backpressure_o;
  logic        skip_backoff_o, sys_reset_busy_o, clock_output_pin_o;
  logic [47:0] station_addr_o;
  int          n_fail = 0;
  int          checked = 0;
  ectl_init_top #(.FACTORY_ADDR(FADDR)) dut (.*);
  ectl_host_model host (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
    .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bus access; a lost answer ends the run
  task automatic acc(input bit w, input logic [5:0] a, input logic [15:0] d, output logic [15:0] r);
    host.xfer(w, a, d, r);
    if (host.to_seen) begin
      n_fail++;
      end_of_test();
    end
  endtask
  // Rising edges of the clock output over 10 us, one edge of phase slack
  task automatic rate(input int exp);
    int n;
    logic p;
    n = 0;
    p = clock_output_pin_o;
    repeat (500) begin
      @(posedge clk_i);
      if (clock_output_pin_o === 1'b1 && p === 1'b0) n++;
      p = clock_output_pin_o;
    end
    chk(n >= exp - 1 && n <= exp + 1, 1);
  endtask
  // Length gate for both directions under a given MAC control value
  task automatic t_len(input logic [15:0] len, input logic [15:0] m, input logic e);
    logic [15:0] r;
    acc(1'b1, OFS_MAC_CTRL_TWO, m, r);
    tx_frame_len_i <= len;
    rx_frame_len_i <= len;
    tx_start_addr_i <= len;
    repeat (3) @(posedge clk_i);
    chk(tx_len_ok_o, e);
    chk(rx_len_ok_o, e);
    chk(tx_rd_addr_o, len);
  endtask
  // Gap length after one transmission end
  task automatic gap(input int exp);
    int n;
    tx_done_i <= 1'b1;
    @(posedge clk_i);
    tx_done_i <= 1'b0;
    @(posedge clk_i);
    n = 0;
    while (tx_gap_busy_o === 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(n, exp);
    if (n >= 300) end_of_test();
  endtask
  // Receive pointer starts at the start pointer and wraps after the last address
  task automatic t_rx();
    logic [15:0] r;
    acc(1'b1, OFS_RX_START, 16'h5ffe, r); // Even start
    acc(1'b1, OFS_CTRL_ONE, 16'h0001, r); // Enabled last
    chk(receive_enable_o, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(rx_wr_addr_o, 16'h5ffe);
    for (int i = 0; i < 2; i++) begin
      rx_byte_i <= 1'b1;
      @(posedge clk_i);
      rx_byte_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(rx_wr_addr_o, i ? 16'h5ffe : 16'h5fff);
    end
  endtask
  // Half then full duplex: gated bits, gaps, retry limit
  task automatic t_duplex();
    logic [15:0] r;
    acc(1'b1, OFS_NBB_GAP, 16'h0012, r);
    acc(1'b1, OFS_MAC_CTRL_TWO, 16'h70b2, r);
    chk({busy_wait_o, backpressure_o, skip_backoff_o}, 3'b111);
    gap((18 + HALF_GAP_OFFSET) * NIBBLE_CYCLES);
    phy_duplex_status_i <= 1'b1;
    repeat (256 * CLK_MHZ) @(posedge clk_i); // PHY status unusable this long after reset
    acc(1'b0, OFS_STATUS, 16'h0000, r);
    chk(r[BIT_PHY_DUPLEX], 1'b1);
    acc(1'b1, OFS_MAC_CTRL_TWO, 16'h70b2 | {15'h0000, r[BIT_PHY_DUPLEX]}, r);
    chk({busy_wait_o, backpressure_o, skip_backoff_o}, 3'b000);
    gap((18 + FULL_GAP_OFFSET) * NIBBLE_CYCLES);
    acc(1'b1, OFS_COLL_CTRL, 16'h0005, r);
    chk(retry_limit_o, 4'h5);
  endtask
  // System reset keeps the clock select, reloads the address, clears itself
  task automatic t_sysrst();
    logic [15:0] r;
    bit ok;
    acc(1'b1, OFS_STA_ADDR0, 16'h1111, r);
    acc(1'b1, OFS_CTRL_TWO, 16'hca00, r);
    host.init_seq(16'hca00, ok);
    chk(ok, 1'b1);
    chk(receive_enable_o, 1'b0);
    acc(1'b0, OFS_STA_ADDR0, 16'h0000, r);
    chk(r, FADDR[15:0]);
    chk(station_addr_o == FADDR, 1'b1);
    acc(1'b0, OFS_CTRL_TWO, 16'h0000, r);
    chk(r, 16'hca00);
    acc(1'b1, 6'h3c, 16'h05e1, r); // No PHY here, write ignored
    acc(1'b0, 6'h3c, 16'h0000, r);
    chk(r, 16'h0000);
    rate(50);
  endtask
  // Power-on reset in mid-run brings the clock output back to 4 MHz
  task automatic t_por();
    bit ok;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    host.init_seq(RST_CTRL_TWO, ok);
    chk(ok, 1'b1);
    rate(40);
  endtask
  // Main sequence
  initial begin
    bit ok;
    logic [15:0] r;
    {rst_n_i, phy_duplex_status_i, rx_byte_i, tx_done_i} = 4'h0;
    {rx_frame_len_i, tx_start_addr_i, tx_frame_len_i} = 48'h0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    host.init_seq(RST_CTRL_TWO, ok);
    chk(ok, 1'b1);
    rate(40);
    acc(1'b1, OFS_MAX_FRAME, 16'h0100, r);
    t_len(16'h0101, 16'h40b2, 1'b0);
    t_len(16'h0100, 16'h40b2, 1'b1);
    t_len(16'h0101, 16'h40b6, 1'b1);
    t_rx();
    t_duplex();
    t_sysrst();
    t_por();
    end_of_test();
  end
endmodule
